// ===== include/cnfs_defs.vh
`ifndef CNFS_DEFS_VH
`define CNFS_DEFS_VH

// object dictionary indices
`define OD_DEVICE_TYPE 16'h1000
`define OD_FAULT_SUMMARY 16'h1001
`define OD_NODE_STATE 16'h1002
`define OD_PDO_COUNT 16'h1004
`define OD_STATION 16'h100b
`define OD_SUP_PERIOD 16'h100c
`define OD_SUP_MULT 16'h100d
`define OD_GUARD_ID 16'h100e
`define OD_SDO_COUNT 16'h100f
`define OD_ALARM_ID 16'h1014
`define OD_SDO_SRV 16'h1200
`define OD_RXPDO_COMM 16'h1400
`define OD_RXPDO_MAP 16'h1600
`define OD_TXPDO_COMM 16'h1800
`define OD_TXPDO_MAP 16'h1a00

// dictionary reset and fixed values
`define RST_DEVICE_TYPE 32'h00000000
`define RST_PDO_COUNT 32'h00010001
`define RST_SDO_COUNT 32'h00000001
`define RST_PARAM_CNT 32'h00000002
`define RST_SUP_PERIOD 16'h0000
`define RST_SUP_MULT 8'h00
`define BASE_GUARD_ID 11'h700
`define BASE_ALARM_ID 11'h080
`define BASE_TPDO_ID 11'h180

// received frame kinds
`define RX_NMT 3'h0
`define RX_GUARD_RTR 3'h1
`define RX_RPDO 3'h2
`define RX_TPDO_RTR 3'h3

// transmitted frame kinds
`define TX_GUARD 2'h0
`define TX_TPDO 2'h1
`define TX_ALARM 2'h2

// network management commands
`define NMT_START 8'h01
`define NMT_STOP 8'h02
`define NMT_PREOP 8'h80
`define NMT_RESET_NODE 8'h81
`define NMT_RESET_COMM 8'h82

// node state codes
`define ST_PREOP 7'h7f
`define ST_OPER 7'h05
`define ST_STOPPED 7'h04

// alarm codes
`define EC_NONE 16'h0000
`define EC_DRIVE 16'hffff
`define EC_LIFEGUARD 16'h8130
`define EC_AUX_SUPPLY 16'h3100

// drive link fault pattern
`define LINK_FAULT_CODE 8'h5b
`define LINK_FAULT_SW1 16'h5b20
`define LINK_FAULT_CUR 16'h0000
`define LINK_FAULT_SW2 16'h0020
`define CTRL_RESET_BIT 6

// timing
`define CLK_PERIOD_NS 10
`define MS_IN_NS 1000000
`define CYC_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define MIN_TIMEOUT_MS 24'd5

`endif

// ===== hdl/cnfs_skid_buf.v
`timescale 1ns/100ps
`default_nettype none
// two-entry buffer between the frame sources and the controller
module cnfs_skid_buf #(
    parameter W = 81
) (
    input wire sys_clk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [W-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [W-1:0] outData
);
    reg [W-1:0] mem [0:1];
    reg rdPtr_reg;
    reg wrPtr_reg;
    reg [1:0] count_reg;
    wire doWrite;
    wire doRead;

    assign inReady = (count_reg != 2'd2);
    assign outValid = (count_reg != 2'd0);
    assign outData = mem[rdPtr_reg];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    ////////////////////////////////////////////////////////////////////////
    // storage and pointers
    always @(posedge sys_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdPtr_reg <= 1'b0;
            wrPtr_reg <= 1'b0;
            count_reg <= 2'd0;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (doRead) begin
                rdPtr_reg <= ~rdPtr_reg;
            end
            if (doWrite && !doRead) begin
                count_reg <= count_reg + 2'd1;
            end else if (doRead && !doWrite) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end
endmodule // cnfs_skid_buf
`default_nettype wire

// ===== hdl/cnfs_alarm_fmt.v
`timescale 1ns/100ps
`default_nettype none
// builds the eight alarm frame bytes, byte 0 in the low bits
module cnfs_alarm_fmt (
    input wire [15:0] errCode,
    input wire [7:0] faultSummary,
    input wire [15:0] driveStatus,
    output wire [63:0] frameData
);
    // code, summary, zero, status word, two zero bytes
    assign frameData = {8'h00, 8'h00, driveStatus[15:8], driveStatus[7:0],
                        8'h00, faultSummary, errCode[15:8], errCode[7:0]};
endmodule // cnfs_alarm_fmt
`default_nettype wire

// ===== hdl/cnfs_node.v
`timescale 1ns/100ps
`default_nettype none
`include "cnfs_defs.vh"
module cnfs_node #(
    parameter CYC_PER_MS = `CYC_PER_MS,
    parameter PD_WORDS = 3
) (
    input wire sys_clk,
    input wire rst,
    input wire [6:0] stationId,
    input wire rxValid,
    input wire [2:0] rxKind,
    input wire [63:0] rxData,
    input wire odReq,
    input wire odWrite,
    input wire [15:0] odIndex,
    input wire [31:0] odWdata,
    output reg odAck,
    output reg odErr,
    output reg [31:0] odRdata,
    input wire driveLinkOk,
    input wire [15:0] driveStatus1,
    input wire [15:0] driveCurrent,
    input wire [15:0] driveStatus2,
    input wire driveFault,
    input wire driveAuxOnly,
    input wire [7:0] digIn,
    input wire timeoutReactionDisable,
    output reg [15:0] poWord1,
    output reg [15:0] poWord2,
    output reg [15:0] poWord3,
    output reg [7:0] digOut,
    output reg driveBlock,
    output reg [7:0] diagFaultCode,
    output reg systemFaultIndicator,
    output reg guardLed,
    output reg [23:0] timeoutReadback,
    output wire txValid,
    input wire txReady,
    output wire [1:0] txKind,
    output wire [10:0] txId,
    output wire [3:0] txLen,
    output wire [63:0] txData
);
    localparam TXW = 81;

    reg [6:0] state_reg;
    reg toggle_reg;
    reg guardSeen_reg;
    reg [15:0] period_reg;
    reg [7:0] mult_reg;
    reg [31:0] msPre_reg;
    reg [23:0] msCnt_reg;
    reg lgExpired_reg;
    reg fbTimeout_reg;
    reg [15:0] rxW1_reg;
    reg [15:0] rxW2_reg;
    reg [15:0] rxW3_reg;
    reg [7:0] rxDo_reg;
    reg pendGuard_reg;
    reg pendTpdo_reg;
    reg pendAlarm_reg;
    reg [15:0] alarmCode_reg;
    reg prevFault_reg;
    reg prevAux_reg;
    reg anyFault_reg;

    wire sysFault;
    wire [15:0] piW1;
    wire [15:0] piW2;
    wire [15:0] piW3;
    wire forRx;
    wire guardEvt;
    wire rpdoEvt;
    wire tpdoRtr;
    wire nmtEvt;
    wire supOn;
    wire msTick;
    wire expireNow;
    wire [23:0] candMs;
    wire [7:0] faultSummary;
    wire [63:0] alarmData;
    wire bufReady;
    reg bufValid;
    reg [TXW-1:0] bufData;
    wire sendGuard;
    wire sendAlarm;
    wire sendTpdo;
    wire faultRise;
    wire auxRise;
    wire allClear;
    wire zeroOut;

    ////////////////////////////////////////////////////////////////////////
    // dictionary read decode
    function [31:0] odLookup;
        input [15:0] idx;
        input [6:0] st;
        input [7:0] fs;
        input [6:0] sid;
        input [15:0] per;
        input [7:0] mul;
        begin
            case (idx)
                `OD_DEVICE_TYPE: odLookup = `RST_DEVICE_TYPE;
                `OD_FAULT_SUMMARY: odLookup = {24'h0, fs};
                `OD_NODE_STATE: odLookup = {25'h0, st};
                `OD_PDO_COUNT: odLookup = `RST_PDO_COUNT;
                `OD_STATION: odLookup = {25'h0, sid};
                `OD_SUP_PERIOD: odLookup = {16'h0, per};
                `OD_SUP_MULT: odLookup = {24'h0, mul};
                `OD_GUARD_ID: odLookup = {21'h0, `BASE_GUARD_ID + {4'h0, sid}};
                `OD_SDO_COUNT: odLookup = `RST_SDO_COUNT;
                `OD_ALARM_ID: odLookup = {21'h0, `BASE_ALARM_ID + {4'h0, sid}};
                `OD_SDO_SRV: odLookup = `RST_PARAM_CNT;
                `OD_RXPDO_COMM: odLookup = `RST_PARAM_CNT;
                `OD_RXPDO_MAP: odLookup = PD_WORDS;
                `OD_TXPDO_COMM: odLookup = `RST_PARAM_CNT;
                `OD_TXPDO_MAP: odLookup = PD_WORDS;
                default: odLookup = 32'h0;
            endcase
        end
    endfunction

    function odKnown;
        input [15:0] idx;
        begin
            case (idx)
                `OD_DEVICE_TYPE, `OD_FAULT_SUMMARY, `OD_NODE_STATE, `OD_PDO_COUNT,
                `OD_STATION, `OD_SUP_PERIOD, `OD_SUP_MULT, `OD_GUARD_ID,
                `OD_SDO_COUNT, `OD_ALARM_ID, `OD_SDO_SRV, `OD_RXPDO_COMM,
                `OD_RXPDO_MAP, `OD_TXPDO_COMM, `OD_TXPDO_MAP: odKnown = 1'b1;
                default: odKnown = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // drive link fault and input words
    assign sysFault = !driveLinkOk;
    assign piW1 = sysFault ? `LINK_FAULT_SW1 : driveStatus1;
    assign piW2 = sysFault ? `LINK_FAULT_CUR : driveCurrent;
    assign piW3 = sysFault ? `LINK_FAULT_SW2 : driveStatus2;
    assign faultSummary = {3'h0, lgExpired_reg, 3'h0, anyFault_reg};

    // frame decode
    assign forRx = rxValid && (state_reg != `ST_STOPPED);
    assign nmtEvt = rxValid && (rxKind == `RX_NMT)
                    && (rxData[15:8] == 8'h00 || rxData[14:8] == stationId);
    assign guardEvt = rxValid && (rxKind == `RX_GUARD_RTR);
    assign rpdoEvt = forRx && (rxKind == `RX_RPDO) && (state_reg == `ST_OPER);
    assign tpdoRtr = forRx && (rxKind == `RX_TPDO_RTR) && (state_reg == `ST_OPER);

    // supervision timing
    assign candMs = odIndex == `OD_SUP_PERIOD ?
                    odWdata[15:0] * {16'h0, mult_reg} :
                    period_reg * {16'h0, odWdata[7:0]};
    assign supOn = guardSeen_reg && (period_reg != 16'h0 || mult_reg != 8'h0)
                   && (timeoutReadback != 24'h0);
    assign msTick = (msPre_reg == CYC_PER_MS - 1);
    assign expireNow = supOn && !lgExpired_reg && msTick
                       && (msCnt_reg + 24'd1 >= timeoutReadback);
    assign zeroOut = fbTimeout_reg && !timeoutReactionDisable;

    ////////////////////////////////////////////////////////////////////////
    // node state machine
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= `ST_PREOP;
        end else if (nmtEvt) begin
            case (rxData[7:0])
                `NMT_START: state_reg <= `ST_OPER;
                `NMT_STOP: state_reg <= `ST_STOPPED;
                `NMT_PREOP: state_reg <= `ST_PREOP;
                `NMT_RESET_NODE: state_reg <= `ST_PREOP;
                `NMT_RESET_COMM: state_reg <= `ST_PREOP;
                default: state_reg <= state_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dictionary access, refused in stopped state
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            odAck <= 1'b0;
            odErr <= 1'b0;
            odRdata <= 32'h0;
            period_reg <= `RST_SUP_PERIOD;
            mult_reg <= `RST_SUP_MULT;
            timeoutReadback <= 24'h0;
        end else begin
            odAck <= odReq;
            odErr <= 1'b0;
            if (odReq) begin
                odRdata <= odLookup(odIndex, state_reg, faultSummary, stationId,
                                    period_reg, mult_reg);
                if (state_reg == `ST_STOPPED || !odKnown(odIndex)) begin
                    odErr <= 1'b1;
                end else if (odWrite) begin
                    if (odIndex == `OD_SUP_PERIOD) begin
                        period_reg <= odWdata[15:0];
                    end else if (odIndex == `OD_SUP_MULT) begin
                        mult_reg <= odWdata[7:0];
                    end else begin
                        odErr <= 1'b1;
                    end
                    // a short product leaves the old timeout in force
                    if ((odIndex == `OD_SUP_PERIOD || odIndex == `OD_SUP_MULT)
                        && candMs >= `MIN_TIMEOUT_MS) begin
                        timeoutReadback <= candMs;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // guarding, life guard counter and bus timeout
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            guardSeen_reg <= 1'b0;
            guardLed <= 1'b0;
            msPre_reg <= 32'h0;
            msCnt_reg <= 24'h0;
            lgExpired_reg <= 1'b0;
            fbTimeout_reg <= 1'b0;
            driveBlock <= 1'b0;
        end else begin
            if (guardEvt) begin
                guardSeen_reg <= 1'b1;
                guardLed <= 1'b1;
            end
            if (guardEvt || !supOn) begin
                msPre_reg <= 32'h0;
                msCnt_reg <= 24'h0;
            end else if (msTick) begin
                msPre_reg <= 32'h0;
                msCnt_reg <= msCnt_reg + 24'd1;
            end else begin
                msPre_reg <= msPre_reg + 32'd1;
            end
            if (guardEvt) begin
                lgExpired_reg <= 1'b0;
            end else if (expireNow) begin
                lgExpired_reg <= 1'b1;
            end
            if (expireNow) begin
                fbTimeout_reg <= 1'b1;
            end else if (rxValid) begin
                fbTimeout_reg <= 1'b0;
            end
            driveBlock <= (lgExpired_reg && !guardEvt) || expireNow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output words towards the drive
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxW1_reg <= 16'h0;
            rxW2_reg <= 16'h0;
            rxW3_reg <= 16'h0;
            rxDo_reg <= 8'h0;
            poWord1 <= 16'h0;
            poWord2 <= 16'h0;
            poWord3 <= 16'h0;
            digOut <= 8'h0;
            diagFaultCode <= 8'h0;
            systemFaultIndicator <= 1'b0;
        end else begin
            if (rpdoEvt) begin
                rxW1_reg <= rxData[15:0];
                rxW2_reg <= rxData[31:16];
                rxW3_reg <= rxData[47:32];
                rxDo_reg <= rxData[55:48];
            end
            if (zeroOut) begin
                poWord1 <= 16'h0;
                poWord2 <= 16'h0;
                poWord3 <= 16'h0;
                digOut <= 8'h0;
            end else begin
                poWord1 <= rxW1_reg;
                poWord1[`CTRL_RESET_BIT] <= rxW1_reg[`CTRL_RESET_BIT] && !sysFault;
                poWord2 <= rxW2_reg;
                poWord3 <= rxW3_reg;
                digOut <= rxDo_reg;
            end
            diagFaultCode <= sysFault ? `LINK_FAULT_CODE : 8'h0;
            systemFaultIndicator <= sysFault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm tracking; events set the pending flag over any clear
    assign faultRise = driveFault && !prevFault_reg;
    assign auxRise = driveAuxOnly && !prevAux_reg;
    assign allClear = anyFault_reg && !driveFault && !driveAuxOnly
                      && !lgExpired_reg && !expireNow;
    assign sendAlarm = pendAlarm_reg && bufReady;
    assign sendGuard = pendGuard_reg && bufReady && !pendAlarm_reg;
    assign sendTpdo = pendTpdo_reg && bufReady && !pendAlarm_reg && !pendGuard_reg;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prevFault_reg <= 1'b0;
            prevAux_reg <= 1'b0;
            anyFault_reg <= 1'b0;
            pendAlarm_reg <= 1'b0;
            alarmCode_reg <= `EC_NONE;
        end else begin
            prevFault_reg <= driveFault;
            prevAux_reg <= driveAuxOnly;
            if (expireNow) begin
                alarmCode_reg <= `EC_LIFEGUARD;
                pendAlarm_reg <= 1'b1;
                anyFault_reg <= 1'b1;
            end else if (faultRise) begin
                alarmCode_reg <= `EC_DRIVE;
                pendAlarm_reg <= 1'b1;
                anyFault_reg <= 1'b1;
            end else if (auxRise) begin
                alarmCode_reg <= `EC_AUX_SUPPLY;
                pendAlarm_reg <= 1'b1;
                anyFault_reg <= 1'b1;
            end else if (allClear && !pendAlarm_reg) begin
                alarmCode_reg <= `EC_NONE;
                pendAlarm_reg <= 1'b1;
                anyFault_reg <= 1'b0;
            end else if (sendAlarm) begin
                pendAlarm_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // guard answers and input frames
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            toggle_reg <= 1'b0;
            pendGuard_reg <= 1'b0;
            pendTpdo_reg <= 1'b0;
        end else begin
            if (guardEvt) begin
                pendGuard_reg <= 1'b1;
            end else if (sendGuard) begin
                pendGuard_reg <= 1'b0;
            end
            if (sendGuard) begin
                toggle_reg <= ~toggle_reg;
            end
            if (rpdoEvt || tpdoRtr) begin
                pendTpdo_reg <= 1'b1;
            end else if (sendTpdo) begin
                pendTpdo_reg <= 1'b0;
            end
        end
    end

    cnfs_alarm_fmt u_alarm (
        .errCode(alarmCode_reg),
        .faultSummary(faultSummary),
        .driveStatus(piW1),
        .frameData(alarmData)
    );

    // one frame per cycle into the buffer, alarm first
    always @* begin
        bufValid = sendAlarm || sendGuard || sendTpdo;
        if (sendAlarm) begin
            bufData = {`TX_ALARM, `BASE_ALARM_ID + {4'h0, stationId}, 4'd8, alarmData};
        end else if (sendGuard) begin
            bufData = {`TX_GUARD, `BASE_GUARD_ID + {4'h0, stationId}, 4'd1,
                       56'h0, toggle_reg, state_reg};
        end else begin
            bufData = {`TX_TPDO, `BASE_TPDO_ID + {4'h0, stationId}, 4'd7,
                       8'h0, digIn, piW3, piW2, piW1};
        end
    end

    cnfs_skid_buf #(
        .W(TXW)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(bufValid),
        .inReady(bufReady),
        .inData(bufData),
        .outValid(txValid),
        .outReady(txReady),
        .outData({txKind, txId, txLen, txData})
    );
endmodule // cnfs_node
`default_nettype wire

// ===== hdl/cnfs_unused_placeholder_never.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== verification/cnfs_node_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// port checker for the node
module cnfs_node_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [6:0] stationId,
    input wire logic rxValid,
    input wire logic [2:0] rxKind,
    input wire logic odReq,
    input wire logic odAck,
    input wire logic driveLinkOk,
    input wire logic timeoutReactionDisable,
    input wire logic [15:0] poWord1,
    input wire logic [7:0] digOut,
    input wire logic driveBlock,
    input wire logic [7:0] diagFaultCode,
    input wire logic systemFaultIndicator,
    input wire logic guardLed,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [1:0] txKind,
    input wire logic [10:0] txId,
    input wire logic [3:0] txLen,
    input wire logic [63:0] txData
);
    logic lastTog;
    logic fbMir;
    // bus timeout mirror: set as the block rises, cleared by any frame
    always @(posedge sys_clk or posedge rst)
        if (rst) fbMir <= 1'b0;
        else fbMir <= !rxValid && (fbMir || $rose(driveBlock));
    // last guard toggle; 1 after reset so the first is 0
    always @(posedge sys_clk or posedge rst) begin
        if (rst)
            lastTog <= 1'b1;
        else if (txValid && txReady && txKind == 2'h0)
            lastTog <= txData[7];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_guardReq;
        rxValid && rxKind == 3'h1;
    endsequence
    sequence s_guardOut;
        txValid && txReady && txKind == 2'h0;
    endsequence
    a_link_fault_flag:
        assert property (!driveLinkOk |=> diagFaultCode == 8'h5b && systemFaultIndicator)
        else $error("link loss not flagged");
    a_link_fault_clear:
        assert property (driveLinkOk |=> !systemFaultIndicator && diagFaultCode == 8'h00)
        else $error("link fault not cleared");
    a_toggle_alternates:
        assert property (s_guardOut |-> txData[7] != lastTog)
        else $error("guard toggle did not alternate");
    a_guard_led_on:
        assert property (s_guardReq |-> ##2 guardLed)
        else $error("guard indicator not on");
    a_guard_frame_shape:
        assert property (txValid && txKind == 2'h0 |-> txLen == 4'h1
            && txId == 11'h700 + {4'h0, stationId})
        else $error("guard frame malformed");
    a_alarm_frame_shape:
        assert property (txValid && txKind == 2'h2 |-> txLen == 4'h8 && txData[31:24] == 8'h00
            && txData[63:48] == 16'h0000 && txId == 11'h080 + {4'h0, stationId})
        else $error("alarm frame malformed");
    a_tx_held_stall:
        assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txKind))
        else $error("frame changed while stalled");
    a_od_ack_delay:
        assert property (odAck == $past(odReq))
        else $error("dictionary answer late");
    a_block_zeroes:
        assert property (fbMir && !$past(timeoutReactionDisable)
            |-> poWord1 == 16'h0000 && digOut == 8'h00)
        else $error("outputs not zeroed on timeout");
endmodule // cnfs_node_assertions
bind cnfs_node cnfs_node_assertions chk (.*);
`default_nettype wire

// ===== verification/cnfs_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// network master: sends frames, collects answers
module cnfs_master_model (
    input wire logic sys_clk,
    input wire logic [1:0] stallMode,
    output logic rxValid,
    output logic [2:0] rxKind,
    output logic [63:0] rxData,
    input wire logic txValid,
    output logic txReady,
    input wire logic [1:0] txKind,
    input wire logic [63:0] txData
);
    logic [65:0] q[$];
    initial begin
        {rxValid, rxKind, rxData} = 68'h0;
        txReady = 1'b1;
    end
    // one frame, one cycle
    task send(input logic [2:0] k, input logic [63:0] d);
        @(negedge sys_clk);
        rxValid = 1'b1;
        rxKind = k;
        rxData = d;
        @(negedge sys_clk);
        rxValid = 1'b0;
        rxData = ~d;
    endtask
    // ready: prompt, alternating or held off
    always @(negedge sys_clk) begin
        txReady <= stallMode == 2'h0 ? 1'b1 : (stallMode == 2'h1 ? ~txReady : 1'b0);
    end
    // collect each accepted frame
    always @(posedge sys_clk) begin
        if (txValid && txReady)
            q.push_back({txKind, txData});
    end
endmodule // cnfs_master_model
`default_nettype wire

// ===== verification/canopen_node_fault_supervision_test.sv
`timescale 1ns/100ps
`default_nettype none
module canopen_node_fault_supervision_test;
    localparam int CPM = 10;
    logic sys_clk = 0, rst = 1, odReq = 0, odWrite = 0, odAck, odErr, rxValid, txValid;
    logic driveLinkOk = 1, driveFault = 0, driveAuxOnly = 0, timeoutReactionDisable = 0;
    logic txReady, driveBlock, systemFaultIndicator, guardLed;
    logic [1:0] stallMode = 2'h0, txKind;
    logic [2:0] rxKind;
    logic [3:0] txLen;
    logic [6:0] stationId = 7'h05;
    logic [7:0] digIn = 8'h00, digOut, diagFaultCode;
    logic [10:0] txId;
    logic [15:0] odIndex = 0, driveStatus1 = 0, driveCurrent = 0, driveStatus2 = 0;
    logic [15:0] poWord1, poWord2, poWord3;
    logic [23:0] timeoutReadback;
    logic [31:0] odWdata = 0, odRdata;
    logic [63:0] rxData, txData, fr, pd;
    logic [15:0] regIdx [8] = '{16'h1000, 16'h1004, 16'h100f, 16'h1200, 16'h1400, 16'h1800,
        16'h100c, 16'h100d};
    logic [31:0] regVal [8] = '{32'h0, 32'h10001, 32'h1, 32'h2, 32'h2, 32'h2, 32'h0, 32'h0};
    integer fails = 0, n_tests = 0, seed = 32'haa37, tog = 0, i;
    always #5 sys_clk = ~sys_clk;
    cnfs_node #(.CYC_PER_MS(CPM)) dut (.*);
    cnfs_master_model mst (.*);
    task complete_run;
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one dictionary access; answer valid on return
    task od(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        @(negedge sys_clk);
        odReq = 1'b1;
        odWrite = w;
        odIndex = idx;
        odWdata = wd;
        @(negedge sys_clk);
        odReq = 1'b0;
    endtask
    // wait for a frame of kind k into fr
    task take(input logic [1:0] k);
        integer n, j;
        logic f;
        f = 1'b0;
        for (n = 0; n < 300 && !f; n++) begin
            for (j = 0; j < mst.q.size(); j++) if (!f && mst.q[j][65:64] === k) begin
                fr = mst.q[j][63:0];
                mst.q.delete(j);
                f = 1'b1;
            end
            if (!f) @(negedge sys_clk);
        end
        chk("frame", 1'b1, f);
    endtask
    task gchk(input logic [6:0] st);
        take(2'h0);
        chk("guard", {tog[0], st}, fr[7:0]);
        tog = 1 - tog;
    endtask
    task guard(input logic [6:0] st);
        mst.send(3'h1, 64'h0);
        gchk(st);
    endtask
    task tpdo;
        take(2'h1);
        chk("tx pdo", driveLinkOk ? {digIn, driveStatus2, driveCurrent, driveStatus1}
            : {digIn, 48'h0020_0000_5b20}, fr[55:0]);
    endtask
    task alarm(input logic [15:0] c);
        take(2'h2);
        chk("alarm", {driveStatus1, c == 16'h0 ? 8'h00 : (c == 16'h8130 ? 8'h11 : 8'h01), c},
            {fr[47:32], fr[23:16], fr[15:0]});
    endtask
    // watchdog
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        {driveStatus1, driveCurrent} = $random(seed);
        {driveStatus2, digIn} = $random(seed);
        pd = {$random(seed), $random(seed)};
        for (i = 0; i < 8; i++) begin
            od(1'b0, regIdx[i], 32'h0);
            chk("od reset", {1'b0, regVal[i]}, {odErr, odRdata});
        end
        od(1'b0, 16'h1234, 32'h0);
        chk("od unmapped", 1'b1, odErr);
        od(1'b1, 16'h1000, 32'h5);
        chk("od ro write", 1'b1, odErr);
        guard(7'h7f);
        guard(7'h7f);
        chk("guard led", 1'b1, guardLed);
        repeat (100) @(negedge sys_clk);
        chk("no supervision", 1'b0, driveBlock);
        mst.send(3'h2, pd);
        repeat (8) @(negedge sys_clk);
        chk("preop pdo", 48'h0, {mst.q.size(), poWord1});
        mst.send(3'h0, 64'h01);
        mst.send(3'h2, pd);
        tpdo();
        chk("po words", pd[55:0], {digOut, poWord3, poWord2, poWord1});
        mst.send(3'h3, 64'h0);
        tpdo();
        driveLinkOk = 1'b0;
        digIn = $random(seed);
        mst.send(3'h3, 64'h0);
        tpdo();
        chk("fault code", 8'h5b, diagFaultCode);
        mst.send(3'h2, pd | 64'h40);
        tpdo();
        chk("reset masked", 1'b0, poWord1[6]);
        driveLinkOk = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("fault cleared", 9'h0, {systemFaultIndicator, diagFaultCode});
        for (i = 0; i < 2; i++) begin
            {driveAuxOnly, driveFault} = i ? 2'b10 : 2'b01;
            alarm(i ? 16'h3100 : 16'hffff);
            {driveAuxOnly, driveFault} = 2'b00;
            alarm(16'h0000);
        end
        od(1'b1, 16'h100c, 32'h2);
        od(1'b1, 16'h100d, 32'h2);
        chk("short rejected", 24'h0, timeoutReadback);
        od(1'b1, 16'h100d, 32'h3);
        chk("timeout ms", 24'h6, timeoutReadback);
        od(1'b1, 16'h100d, 32'h2);
        chk("old kept", 24'h6, timeoutReadback);
        guard(7'h05);
        repeat (40) @(negedge sys_clk);
        guard(7'h05);
        repeat (40) @(negedge sys_clk);
        chk("restarted", 1'b0, driveBlock);
        repeat (50) @(negedge sys_clk);
        chk("expired", {1'b1, 56'h0}, {driveBlock, digOut, poWord3, poWord2, poWord1});
        alarm(16'h8130);
        guard(7'h05);
        alarm(16'h0000);
        mst.send(3'h2, pd);
        tpdo();
        chk("resumed", {1'b0, pd[55:0]}, {driveBlock, digOut, poWord3, poWord2, poWord1});
        timeoutReactionDisable = 1'b1;
        repeat (6 * CPM + 30) @(negedge sys_clk);
        chk("kept", {1'b1, pd[55:0]}, {driveBlock, digOut, poWord3, poWord2, poWord1});
        alarm(16'h8130);
        stallMode = 2'h2;
        mst.send(3'h1, 64'h0);
        mst.send(3'h3, 64'h0);
        repeat (4) @(negedge sys_clk);
        chk("stalled", 1'b1, txValid);
        stallMode = 2'h1;
        gchk(7'h05);
        tpdo();
        stallMode = 2'h0;
        mst.send(3'h0, 64'h02);
        od(1'b0, 16'h1000, 32'h0);
        chk("stopped od", 1'b1, odErr);
        mst.send(3'h2, ~pd);
        repeat (8) @(negedge sys_clk);
        chk("stopped pdo", pd[15:0], poWord1);
        guard(7'h04);
        complete_run();
    end
endmodule // canopen_node_fault_supervision_test
`default_nettype wire
